/* core/qsp_mem_ctrl.sv */
// Controller end of the link: makes the link clocks, issues bursts, collects reads.
// Assumes core_clk is the only clock here; the read bus arrives from the device's domain.
module qsp_mem_ctrl import qsp_pkg::*; (
  qsp_link_if.ctrl lnk,
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [BURST*DW-1:0] cmd_wdata,
  input wire logic [BURST*LANES-1:0] cmd_byte_en,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [BURST*DW-1:0] rsp_data
);

  // ==========================================================================
  // Declarations
  logic [1:0] div_q;
  logic k_q, kn_q, oc_q, ocn_q;
  logic slot_q;
  logic ready_q;
  logic take;
  logic launch;
  logic credit_ok;
  logic rsel_n_q, wsel_n_q;
  logic [AW-1:0] addr_q;
  logic [BURST*DW-1:0] wbuf_q;
  logic [BURST*LANES-1:0] wbe_q;
  logic [DW-1:0] wd_q;
  logic [LANES-1:0] bw_n_q;
  logic [WR_HIST_W-1:0] wr_hist_q;
  logic [RD_HIST_W-1:0] rd_hist_q;
  logic [DW-1:0] rd_s1_q, rd_s2_q;
  logic [DW-1:0] acc_q [0:BURST-2];
  logic push, pop;
  logic [BURST*DW-1:0] push_word;
  logic [1:0] rd_out_q;
  logic [BURST*DW-1:0] rb_q [0:RSP_DEPTH-1];
  logic wp_q, rp_q;
  logic [1:0] cnt_q, cnt_d;
  logic rsp_valid_q;

  // ==========================================================================
  // Link clocks, divided from core_clk
  // Divide by four puts each launch on the core edge between two link edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= DIV_HIGH;
      k_q <= 1'b0;
      kn_q <= 1'b1;
      oc_q <= 1'b0;
      ocn_q <= 1'b1;
    end else begin
      div_q <= div_q + 2'h1;
      // First rise waits a full divider turn, else the device slot flop runs one ahead
      k_q <= (div_q == DIV_RISE) || ((div_q == DIV_HIGH) && k_q); // see [RL12]
      kn_q <= !((div_q == DIV_RISE) || ((div_q == DIV_HIGH) && k_q));
      oc_q <= (div_q == DIV_RISE) || ((div_q == DIV_HIGH) && oc_q); // see [RL15]
      ocn_q <= !((div_q == DIV_RISE) || ((div_q == DIV_HIGH) && oc_q)); // see [RL15]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= 1'b0;
    end else if (div_q == DIV_RISE) begin
      slot_q <= ~slot_q; // see [RL18]
    end
  end

  // ==========================================================================
  // Command intake
  // Reads are refused until the response buffer can take a whole burst
  assign credit_ok = ({1'b0, rd_out_q} + {1'b0, cnt_q}) < 3'(RSP_DEPTH);
  assign take = ready_q & cmd_valid;
  assign launch = (div_q == DIV_HIGH) || (div_q == DIV_ISSUE);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (div_q == DIV_READY) && cmd_valid && (cmd_write == slot_q)
                 && (slot_q || credit_ok); // see [RL18]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsel_n_q <= 1'b1;
      wsel_n_q <= 1'b1;
      addr_q <= '0;
    end else if (div_q == DIV_ISSUE) begin
      rsel_n_q <= ~(take & ~cmd_write); // see [RL8] [RL12]
      wsel_n_q <= ~(take & cmd_write); // see [RL16] [RL12]
      if (take) begin
        addr_q <= cmd_addr; // see [RL5]
      end
    end
  end

  // ==========================================================================
  // Write beats
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wbuf_q <= '0;
      wbe_q <= '0;
      wr_hist_q <= '0;
      rd_hist_q <= '0;
    end else begin
      if (take & cmd_write) begin
        wbuf_q <= cmd_wdata;
        wbe_q <= cmd_byte_en;
      end
      wr_hist_q <= {wr_hist_q[WR_HIST_W-2:0], take & cmd_write};
      rd_hist_q <= {rd_hist_q[RD_HIST_W-2:0], take & ~cmd_write};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wd_q <= '0;
      bw_n_q <= '1;
    end else if (launch) begin
      bw_n_q <= '1;
      for (int j = 0; j < BURST; j++) begin
        if (wr_hist_q[WR_TAP0 + BEAT_STEP * j]) begin
          wd_q <= wbuf_q[j*DW +: DW]; // see [RL17]
          bw_n_q <= ~wbe_q[j*LANES +: LANES]; // see [RL1] [RL4]
        end
      end
    end
  end

  // ==========================================================================
  // Read capture
  // Bus is from another domain; fixed schedule picks each word after the synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_s1_q <= '0;
      rd_s2_q <= '0;
    end else begin
      rd_s1_q <= lnk.rd_bus;
      rd_s2_q <= rd_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int j = 0; j < BURST - 1; j++) begin
        acc_q[j] <= '0;
      end
    end else begin
      for (int j = 0; j < BURST - 1; j++) begin
        if (rd_hist_q[RD_TAP0 + BEAT_STEP * j]) begin
          acc_q[j] <= rd_s2_q; // see [RL9] [RL19]
        end
      end
    end
  end

  assign push = rd_hist_q[RD_TAP0 + BEAT_STEP * (BURST - 1)];

  always_comb begin
    push_word = '0;
    for (int j = 0; j < BURST - 1; j++) begin
      push_word[j*DW +: DW] = acc_q[j];
    end
    push_word[(BURST-1)*DW +: DW] = rd_s2_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_out_q <= '0;
    end else if ((take & ~cmd_write) && !push) begin
      rd_out_q <= rd_out_q + 2'h1;
    end else if (!(take & ~cmd_write) && push) begin
      rd_out_q <= rd_out_q - 2'h1;
    end
  end

  // ==========================================================================
  // Two-entry response buffer
  assign pop = rsp_valid_q & rsp_ready;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_d;
      rsp_valid_q <= cnt_d != 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      rb_q[wp_q] <= push_word;
    end
  end

  // ==========================================================================
  // Outputs
  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rb_q[rp_q];
  assign lnk.main_rise_ref = k_q;
  assign lnk.main_fall_ref = kn_q;
  assign lnk.output_rise_ref = oc_q;
  assign lnk.output_fall_ref = ocn_q;
  assign lnk.addr = addr_q;
  assign lnk.read_port_sel_n = rsel_n_q;
  assign lnk.write_port_sel_n = wsel_n_q;
  assign lnk.byte_lane_write_n = bw_n_q;
  assign lnk.wr_bus_in = wd_q;

endmodule // qsp_mem_ctrl

/* core/qsp_pkg.sv */
// Shared constants, types and helpers for the quad-rate separate-port memory link.
// Assumes both link ends and the bench compile this package first.
package qsp_pkg;

  // ==========================================================================
  // Organisation
  // Clear CFG_WIDE for the 18-bit part, set it for the 36-bit part
  localparam bit CFG_WIDE = 1'b0;
  localparam int LANE_W = 9;
  localparam int LANES = CFG_WIDE ? 4 : 2;
  localparam int DW = LANE_W * LANES;
  localparam int AW = CFG_WIDE ? 18 : 19;
  localparam int BURST = 4;
  localparam int BEAT_W = 2;
  localparam int MEM_WORDS = BURST << AW;

  // ==========================================================================
  // Link timing, in core clock cycles
  localparam int KDIV = 4;
  localparam int RD_LAT_HALF = 3;
  localparam int SYNC_STAGES = 2;
  localparam int BEAT_STEP = KDIV / 2;
  localparam logic [1:0] DIV_HIGH = 2'h0;
  localparam logic [1:0] DIV_READY = 2'h1;
  localparam logic [1:0] DIV_ISSUE = 2'h2;
  localparam logic [1:0] DIV_RISE = 2'h3;
  localparam int WR_TAP0 = 1;
  localparam int WR_HIST_W = WR_TAP0 + BEAT_STEP * (BURST - 1) + 1;
  localparam int RD_TAP0 = 1 + KDIV * RD_LAT_HALF / 2 + SYNC_STAGES;
  localparam int RD_HIST_W = RD_TAP0 + BEAT_STEP * (BURST - 1) + 1;
  localparam int RSP_DEPTH = 2;

  // ==========================================================================
  // States
  typedef enum logic [1:0] {QSP_RD_IDLE, QSP_RD_FIRST, QSP_RD_SECOND} qsp_rd_t;
  typedef enum logic [1:0] {QSP_WR_IDLE, QSP_WR_LOW, QSP_WR_HIGH} qsp_wr_t;

  // ==========================================================================
  // Helpers
  function automatic logic [AW+BEAT_W-1:0] qsp_idx(input logic [AW-1:0] a, input logic [BEAT_W-1:0] b);
    return {a, b};
  endfunction

  // Lanes whose select is high keep the stored byte
  function automatic logic [DW-1:0] qsp_merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                              input logic [LANES-1:0] sel_n);
    logic [DW-1:0] r;
    r = old;
    for (int l = 0; l < LANES; l++) begin
      if (!sel_n[l]) begin
        r[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

endpackage

/* core/qsp_link_if.sv */
// Pin bundle between the memory controller and the memory device.
// Assumes the bench instantiates it once and hands one modport to each end.
interface qsp_link_if import qsp_pkg::*; ();

  // ==========================================================================
  // Pins
  logic main_rise_ref;
  logic main_fall_ref;
  logic output_rise_ref;
  logic output_fall_ref;
  logic [AW-1:0] addr;
  logic read_port_sel_n;
  logic write_port_sel_n;
  logic [LANES-1:0] byte_lane_write_n;
  logic [DW-1:0] wr_bus_in;
  logic [DW-1:0] rd_bus_out;
  logic rd_bus_oe;
  logic echo_strobe;
  logic echo_strobe_n;
  wire [DW-1:0] rd_bus;

  // Board wire of the read bus; released bus shows the inverse so a late capture fails
  assign rd_bus = rd_bus_oe ? rd_bus_out : ~rd_bus_out;

  modport device(
    input main_rise_ref, main_fall_ref, output_rise_ref, output_fall_ref,
    input addr, read_port_sel_n, write_port_sel_n, byte_lane_write_n, wr_bus_in,
    output rd_bus_out, rd_bus_oe, echo_strobe, echo_strobe_n
  );

  modport ctrl(
    output main_rise_ref, main_fall_ref, output_rise_ref, output_fall_ref,
    output addr, read_port_sel_n, write_port_sel_n, byte_lane_write_n, wr_bus_in,
    input rd_bus, echo_strobe, echo_strobe_n
  );

endinterface

/* core/qsp_mem_device.sv */
// Memory device end of the link: storage, write bursts, read bursts, echo strobe.
// Assumes the controller makes all link clocks and keeps the slot rhythm.
// The reset stands in for power-up and has no pin on the real part.

// Summary of operation
// [RL1] Byte selects active low, sampled both edges
// [RL2] Deselected byte lane leaves stored byte unchanged
// [RL3] Select n governs nine-bit lane n
// [RL4] Byte selects sampled with their data beat
// [RL5] One shared address bus, rising main edge
// [RL6] Address width depends on data width
// [RL7] Address ignored when its port idle
// [RL8] Read select low starts read burst
// [RL9] Each read returns four sequential words
// [RL10] Started read finishes, then bus floats
// [RL11] Read data launched on output clock pair
// [RL12] Accesses start on rising main edge
// [RL13] Falling reference also captures data beats
// [RL14] Free-running echo strobe follows output clock
// [RL15] Controller supplies the output clock pair
// [RL16] Write select low starts write burst
// [RL17] Write data sampled on both edges
// [RL18] Read and write addresses alternate slots
// [RL19] First read word after 1.5 cycles
module qsp_mem_device import qsp_pkg::*; (
  qsp_link_if.device lnk,
  input wire logic resetn,
  input wire logic single_clock_mode
);

  // ==========================================================================
  // Storage
  logic [DW-1:0] mem [0:MEM_WORDS-1];

  // ==========================================================================
  // Declarations
  logic slot_q;
  logic rd_go;
  logic wr_go;
  logic [AW-1:0] rd_addr_q;
  logic [AW-1:0] wr_addr_q;
  logic rd_pend_q;
  qsp_rd_t rd_st_q;
  qsp_wr_t wr_st_q;
  logic [DW-1:0] rd_buf_q [0:BURST-1];
  logic [DW-1:0] fall_d_q;
  logic [LANES-1:0] fall_bw_q;
  logic out_rise_clk;
  logic out_fall_clk;
  logic [DW-1:0] q_r_q;
  logic [DW-1:0] q_f_q;
  logic oe_r_q;
  logic oe_f_q;
  logic er_q;
  logic ef_q;

  // ==========================================================================
  // Slot phase and port selects
  // Slot 0 rises carry a read address, slot 1 rises a write address
  always_ff @(posedge lnk.main_rise_ref or negedge resetn) begin
    if (!resetn) begin
      slot_q <= 1'b0;
    end else begin
      slot_q <= ~slot_q; // see [RL18]
    end
  end

  assign rd_go = ~slot_q & ~lnk.read_port_sel_n; // see [RL8]
  assign wr_go = slot_q & ~lnk.write_port_sel_n; // see [RL16]

  // ==========================================================================
  // Address capture
  always_ff @(posedge lnk.main_rise_ref or negedge resetn) begin
    if (!resetn) begin
      rd_addr_q <= '0;
      wr_addr_q <= '0;
    end else begin
      // An idle port leaves its address register alone
      if (rd_go) begin
        rd_addr_q <= lnk.addr; // see [RL5] [RL7] [RL12]
      end
      if (wr_go) begin
        wr_addr_q <= lnk.addr; // see [RL5] [RL7] [RL6]
      end
    end
  end

  // ==========================================================================
  // Read sequencing
  always_ff @(posedge lnk.main_rise_ref or negedge resetn) begin
    if (!resetn) begin
      rd_pend_q <= 1'b0;
      rd_st_q <= QSP_RD_IDLE;
    end else begin
      rd_pend_q <= rd_go;
      if (rd_pend_q) begin
        rd_st_q <= QSP_RD_FIRST; // see [RL19]
      end else begin
        case (rd_st_q)
          QSP_RD_FIRST: begin
            rd_st_q <= QSP_RD_SECOND; // see [RL10]
          end
          default: begin
            rd_st_q <= QSP_RD_IDLE;
          end
        endcase
      end
    end
  end

  // Whole burst fetched at once so the output side never reads the array
  always_ff @(posedge lnk.main_rise_ref) begin
    if (rd_pend_q) begin
      for (int j = 0; j < BURST; j++) begin
        rd_buf_q[j] <= mem[qsp_idx(rd_addr_q, BEAT_W'(j))]; // see [RL9]
      end
    end
  end

  // ==========================================================================
  // Write beats on the falling reference
  always_ff @(posedge lnk.main_fall_ref or negedge resetn) begin
    if (!resetn) begin
      fall_d_q <= '0;
      fall_bw_q <= '1;
    end else begin
      fall_d_q <= lnk.wr_bus_in; // see [RL13] [RL17]
      fall_bw_q <= lnk.byte_lane_write_n; // see [RL1] [RL4]
    end
  end

  // ==========================================================================
  // Write sequencing
  always_ff @(posedge lnk.main_rise_ref or negedge resetn) begin
    if (!resetn) begin
      wr_st_q <= QSP_WR_IDLE;
    end else if (wr_go) begin
      wr_st_q <= QSP_WR_LOW;
    end else begin
      case (wr_st_q)
        QSP_WR_LOW: begin
          wr_st_q <= QSP_WR_HIGH;
        end
        default: begin
          wr_st_q <= QSP_WR_IDLE;
        end
      endcase
    end
  end

  // Two words per rise: the held falling beat and the current rising beat
  always_ff @(posedge lnk.main_rise_ref) begin
    case (wr_st_q)
      QSP_WR_LOW: begin
        mem[qsp_idx(wr_addr_q, 2'h0)] <= qsp_merge(mem[qsp_idx(wr_addr_q, 2'h0)], fall_d_q,
                                                   fall_bw_q); // see [RL2] [RL3]
        mem[qsp_idx(wr_addr_q, 2'h1)] <= qsp_merge(mem[qsp_idx(wr_addr_q, 2'h1)], lnk.wr_bus_in,
                                                   lnk.byte_lane_write_n); // see [RL1] [RL4] [RL17]
      end
      QSP_WR_HIGH: begin
        mem[qsp_idx(wr_addr_q, 2'h2)] <= qsp_merge(mem[qsp_idx(wr_addr_q, 2'h2)], fall_d_q,
                                                   fall_bw_q); // see [RL2] [RL3]
        mem[qsp_idx(wr_addr_q, 2'h3)] <= qsp_merge(mem[qsp_idx(wr_addr_q, 2'h3)], lnk.wr_bus_in,
                                                   lnk.byte_lane_write_n); // see [RL1] [RL4]
      end
      default: begin
      end
    endcase
  end

  // ==========================================================================
  // Output clocking
  // Clock mux stands in for the pad-level selection of the strap
  assign out_rise_clk = single_clock_mode ? lnk.main_rise_ref : lnk.output_rise_ref; // see [RL11] [RL15]
  assign out_fall_clk = single_clock_mode ? lnk.main_fall_ref : lnk.output_fall_ref; // see [RL11] [RL15]

  // ==========================================================================
  // Read launch, rising output clock
  // Output pair must not lead the main pair, else beats shift by a half cycle
  always_ff @(posedge out_rise_clk or negedge resetn) begin
    if (!resetn) begin
      q_r_q <= '0;
      oe_r_q <= 1'b0;
    end else begin
      oe_r_q <= rd_st_q != QSP_RD_IDLE; // see [RL10] [RL11]
      case (rd_st_q)
        QSP_RD_FIRST: begin
          q_r_q <= rd_buf_q[1]; // see [RL9]
        end
        QSP_RD_SECOND: begin
          q_r_q <= rd_buf_q[3]; // see [RL9]
        end
        default: begin
          q_r_q <= q_r_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read launch, falling output clock
  // Last word is held until the next rise so the bus floats only then
  always_ff @(posedge out_fall_clk or negedge resetn) begin
    if (!resetn) begin
      q_f_q <= '0;
      oe_f_q <= 1'b0;
    end else begin
      oe_f_q <= (rd_st_q != QSP_RD_IDLE) | oe_r_q; // see [RL10]
      case (rd_st_q)
        QSP_RD_FIRST: begin
          q_f_q <= rd_buf_q[0]; // see [RL19] [RL9]
        end
        QSP_RD_SECOND: begin
          q_f_q <= rd_buf_q[2]; // see [RL9]
        end
        default: begin
          q_f_q <= q_r_q; // see [RL10]
        end
      endcase
    end
  end

  // ==========================================================================
  // Echo strobe
  always_ff @(posedge out_rise_clk or negedge resetn) begin
    if (!resetn) begin
      er_q <= 1'b0;
    end else begin
      er_q <= ~er_q; // see [RL14]
    end
  end

  always_ff @(posedge out_fall_clk or negedge resetn) begin
    if (!resetn) begin
      ef_q <= 1'b0;
    end else begin
      ef_q <= ~ef_q; // see [RL14]
    end
  end

  // ==========================================================================
  // Pin drive, double-rate mux on the output clock level
  assign lnk.rd_bus_out = out_rise_clk ? q_r_q : q_f_q; // see [RL11]
  assign lnk.rd_bus_oe = out_rise_clk ? oe_r_q : oe_f_q; // see [RL10] [RL11]
  assign lnk.echo_strobe = er_q ^ ef_q; // see [RL14]
  assign lnk.echo_strobe_n = ~(er_q ^ ef_q);

endmodule // qsp_mem_device

/* testbench/qsp_link_props.sv */
// Pin checks between the two link ends, sampled on the link clock pair.
// Assumes the output pair follows the main pair and one reset serves both ends.
module qsp_link_props import qsp_pkg::*; (
  input wire logic main_rise_ref,
  input wire logic main_fall_ref,
  input wire logic resetn,
  input wire logic read_port_sel_n,
  input wire logic write_port_sel_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic rd_bus_oe,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n
);
  default clocking cb @(posedge main_rise_ref);
  endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Read port
  read_burst_a: assert property (
    !read_port_sel_n |-> ##2 rd_bus_oe [*3]) else $error("read burst not driven");
  bus_float_a: assert property (
    rd_bus_oe |-> !$past(read_port_sel_n, 2) || !$past(read_port_sel_n, 3) || !$past(read_port_sel_n, 4))
    else $error("read bus driven without a read");
  read_gap_a: assert property (
    !read_port_sel_n |=> read_port_sel_n) else $error("read selects on adjacent rises");

  // ==========================================================================
  // Echo strobe, sampled on both reference rises
  echo_rise_a: assert property (
    !echo_strobe && echo_strobe_n) else $error("echo strobe wrong at main rise");
  echo_fall_a: assert property (@(posedge main_fall_ref) disable iff (!resetn)
    echo_strobe && !echo_strobe_n) else $error("echo strobe wrong at main fall");

  // ==========================================================================
  // Write port and slots
  lane_rise_a: assert property (
    !(&byte_lane_write_n) |-> !$past(write_port_sel_n) || !$past(write_port_sel_n, 2))
    else $error("byte select outside write burst");
  lane_fall_a: assert property (@(posedge main_fall_ref) disable iff (!resetn)
    !(&byte_lane_write_n) |-> !write_port_sel_n || !$past(write_port_sel_n))
    else $error("byte select outside write beats");
  slot_alt_a: assert property (
    read_port_sel_n || write_port_sel_n) else $error("both ports selected at one rise");
  write_gap_a: assert property (
    !write_port_sel_n |=> write_port_sel_n) else $error("write selects on adjacent rises");

  read_c: cover property (!read_port_sel_n ##2 !read_port_sel_n);
  write_c: cover property (!write_port_sel_n ##1 !(&byte_lane_write_n));
  mixed_c: cover property (!read_port_sel_n ##1 !write_port_sel_n);
endmodule // qsp_link_props

/* testbench/tb_quad_rate_sram_port.sv */
// Bench: controller and device joined by the pin bundle, traffic on the command side.
// Assumes package, interface, both ends and the checker are compiled first.
module tb_quad_rate_sram_port import qsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Design and checker
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic single_clock_mode = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [AW-1:0] cmd_addr = '0;
  logic [BURST*DW-1:0] cmd_wdata = '0;
  logic [BURST*LANES-1:0] cmd_byte_en = '0;
  logic rsp_ready = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic [BURST*DW-1:0] rsp_data;
  qsp_link_if lnk();
  qsp_mem_ctrl i_qsp_mem_ctrl(.lnk(lnk), .core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_byte_en(cmd_byte_en), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
  qsp_mem_device i_qsp_mem_device(.lnk(lnk), .resetn(resetn), .single_clock_mode(single_clock_mode));
  qsp_link_props i_qsp_link_props(.main_rise_ref(lnk.main_rise_ref), .main_fall_ref(lnk.main_fall_ref),
    .resetn(resetn), .read_port_sel_n(lnk.read_port_sel_n), .write_port_sel_n(lnk.write_port_sel_n),
    .byte_lane_write_n(lnk.byte_lane_write_n), .rd_bus_oe(lnk.rd_bus_oe), .echo_strobe(lnk.echo_strobe),
    .echo_strobe_n(lnk.echo_strobe_n));

  // ==========================================================================
  // Model state
  logic [DW-1:0] mem [logic [AW+BEAT_W-1:0]];
  logic [BURST*DW-1:0] exp_q [$];
  logic [AW-1:0] addr_t [6];
  logic [AW-1:0] last_wr = '0;
  logic [31:0] seed = 32'h32DE;
  logic [31:0] seed_r = 32'h32DE;
  logic stall = 1'b0;
  int takes = 0;
  int fail_count = 0;
  int checked = 0;

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int i = 0; i < 16; i++) begin
      r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    end
    return r;
  endfunction

  task automatic bad(input string msg);
    fail_count++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_burst();
    checked++;
    if (exp_q.size() == 0) begin
      bad("response without a read");
    end else if (rsp_data !== exp_q.pop_front()) begin
      bad("read burst differs");
    end
  endtask

  task automatic check_count(input int got, input int want);
    checked++;
    if (got != want) begin
      bad("take count differs");
    end
  endtask

  // ==========================================================================
  // Command driver; model updated when the take is certain
  task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [BURST*LANES-1:0] be);
    int n;
    logic [AW+BEAT_W-1:0] ix;
    logic [BURST*DW-1:0] e;
    seed = lfsr(seed);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_byte_en = be;
    for (int j = 0; j < BURST; j++) begin
      cmd_wdata[j*DW +: DW] = DW'(lfsr(seed + j));
    end
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) begin
      bad("command never taken");
      tally_and_finish();
    end
    for (int j = 0; j < BURST; j++) begin
      ix = {a, BEAT_W'(j)};
      for (int l = 0; l < LANES; l++) begin
        if (wr && be[j*LANES+l]) begin
          mem[ix][l*LANE_W +: LANE_W] = cmd_wdata[j*DW+l*LANE_W +: LANE_W];
        end
      end
      e[j*DW +: DW] = mem[ix];
    end
    if (wr) begin
      last_wr = a;
    end else begin
      exp_q.push_back(e);
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    // Idle edge so a following call never re-raises valid in this step
    @(negedge core_clk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      bad("read responses missing");
      tally_and_finish();
    end
    repeat (2) @(negedge core_clk);
  endtask

  // ==========================================================================
  // Receiver with random stalls
  always @(negedge core_clk) begin
    seed_r = lfsr(seed_r);
    rsp_ready = !stall && seed_r[1:0] != 2'h0;
    if (rsp_valid === 1'b1 && rsp_ready) begin
      check_burst();
    end
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      takes++;
    end
  end

  // ==========================================================================
  // Main sequence: second pass resets mid-run in single clock mode
  initial begin
    int idx;
    int t0;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      addr_t[i] = seed[AW-1:0];
    end
    addr_t[0] = '0;
    addr_t[5] = '1;
    for (int pass = 0; pass < 2; pass++) begin
      single_clock_mode = pass[0];
      resetn = 1'b0;
      repeat (5) @(negedge core_clk);
      resetn = 1'b1;
      if (pass == 0) begin
        foreach (addr_t[i]) issue(1'b1, addr_t[i], '1);
      end
      for (int k = 0; k < 30; k++) begin
        seed = lfsr(seed);
        idx = seed[6:2] % 6;
        if (seed[0]) begin
          issue(1'b1, addr_t[idx], (BURST*LANES)'(seed >> 9));
        end else if (addr_t[idx] != last_wr) begin
          issue(1'b0, addr_t[idx], '0);
        end
      end
      // Empty the buffer first so the credit count starts from zero
      drain();
      // Two bursts fill the buffer; the third read must wait for a pop
      issue(1'b1, addr_t[0], '1);
      stall = 1'b1;
      t0 = takes;
      fork
        begin
          repeat (120) @(negedge core_clk);
          check_count(takes - t0, 2);
          stall = 1'b0;
        end
        for (int k = 1; k < 4; k++) begin
          issue(1'b0, addr_t[k], '0);
        end
      join
      drain();
    end
    tally_and_finish();
  end
endmodule // tb_quad_rate_sram_port
